// ===== hw/byte_alu_subset_exec.sv
// Execution datapath for a subset of an 8-bit core's instructions:
// pointer add, AND/add with literal or file, add with carry, shift, bit clear.
// Assumes the decoder presents the opcode, the operation select and the
// addressed file register's current value in the same cycle, on clk_in.
`timescale 1ns/100ps
`include "byte_alu_regs.svh"
module byte_alu_subset_exec
(
   // Clock and reset
   input  wire logic                     clk_in,
   input  wire logic                     srst_in,
   // Instruction issue from the decoder
   input  wire logic                     issue_valid_in,
   input  wire logic [13:0]              opcode_in,
   input  wire byte_alu_pkg::op_sel_type op_in,
   input  wire logic [7:0]               file_rd_data_in,
   // Direct pointer load from the core
   input  wire logic                     ptr_load_en_in,
   input  wire logic                     ptr_load_sel_in,
   input  wire logic [15:0]              ptr_load_data_in,
   // Issue handshake
   output logic                          busy_out,
   output logic                          done_out,
   // File register write back
   output logic                          file_we_out,
   output logic [6:0]                    file_addr_out,
   output logic [7:0]                    file_data_out,
   // Architectural state
   output logic [7:0]                    acc_out,
   output logic                          carry_out,
   output logic                          nibble_overflow_bit_out,
   output logic                          zero_out,
   output logic [15:0]                   indirect_pointer_pair0_out,
   output logic [15:0]                   indirect_pointer_pair1_out
);
   import byte_alu_pkg::*;

   exec_state_type  state_r;
   exec_result_type hold_r;
   exec_result_type res_nxt;
   exec_result_type commit;
   ptr_write_type   ptr_wr;
   logic [7:0]      acc_r;
   logic            carry_r;
   logic            dc_r;
   logic            zero_r;
   logic            busy_r;
   logic            done_r;
   logic            file_we_r;
   logic [6:0]      file_addr_r;
   logic [7:0]      file_data_r;
   logic [15:0]     ptr0;
   logic [15:0]     ptr1;
   logic            accept;
   logic            is_ptr_add;
   logic            is_file_op;
   logic            stall;
   logic            do_commit;
   logic [6:0]      f_addr;
   logic            dest_file;
   logic [7:0]      opnd_b;
   logic            cin;
   logic [8:0]      sum9;
   logic [4:0]      sum5;
   logic [15:0]     lit_ext;

   assign accept     = issue_valid_in && !busy_r;
   assign f_addr     = opcode_in[`FLD_FILE_ADDR];
   assign dest_file  = opcode_in[`FLD_DEST];
   // Pointer add is recognised from the opcode itself, whatever op_in says
   assign is_ptr_add = (opcode_in[`FLD_PTR_ADD_TOP] == `PTR_ADD_PATTERN);
   // Only legal file codes count, so a stray select code never costs a stall
   assign is_file_op = !is_ptr_add && (op_in inside {OP_AND_ACC_FILE, OP_ADD_ACC_FILE,
                       OP_ADD_ACC_FILE_CARRY_IN, OP_ARITH_SHIFT_RIGHT_FILE, OP_BIT_CLEAR_FILE});

   // Extra cycle when a file op hits an indirect target whose pointer points high
   always_comb
   begin
      stall = 1'b0;
      if (is_file_op && (f_addr == `PTR0_TARGET_ADDR))
         stall = ptr0[`PTR_MSB];
      else if (is_file_op && (f_addr == `PTR1_TARGET_ADDR))
         stall = ptr1[`PTR_MSB];
   end

   // Shared adder: second operand is the literal or the file value
   assign opnd_b  = (op_in == OP_ADD_LITERAL_ACC) ? opcode_in[`FLD_LIT8] : file_rd_data_in;
   assign cin     = (op_in == OP_ADD_ACC_FILE_CARRY_IN) ? carry_r : 1'b0;
   assign sum9    = {1'b0, acc_r} + {1'b0, opnd_b} + {8'h00, cin};
   assign sum5    = {1'b0, acc_r[3:0]} + {1'b0, opnd_b[3:0]} + {4'h0, cin};
   // Signed literal, -32 to 31
   assign lit_ext = {{10{opcode_in[`FLD_LIT6_SIGN]}}, opcode_in[`FLD_LIT6]};

   // Result of the instruction being issued
   always_comb
   begin
      res_nxt           = '0;
      res_nxt.file_addr = f_addr;
      res_nxt.acc_we    = !dest_file;
      res_nxt.file_we   = dest_file;
      if (is_ptr_add)
      begin
         // No flag enables here, and the 16-bit sum drops its carry on purpose
         res_nxt.acc_we  = 1'b0;
         res_nxt.file_we = 1'b0;
         res_nxt.ptr_we  = 1'b1;
         res_nxt.ptr_sel = opcode_in[`FLD_PTR_SEL];
         res_nxt.ptr_val = (opcode_in[`FLD_PTR_SEL] ? ptr1 : ptr0) + lit_ext;
      end
      else
      begin
         unique case (op_in)
            OP_AND_LITERAL_ACC:
            begin
               res_nxt.data    = acc_r & opcode_in[`FLD_LIT8];
               res_nxt.acc_we  = 1'b1;
               res_nxt.file_we = 1'b0;
               res_nxt.z_we    = 1'b1;
            end
            OP_ADD_LITERAL_ACC:
            begin
               res_nxt.data    = sum9[7:0];
               res_nxt.acc_we  = 1'b1;
               res_nxt.file_we = 1'b0;
               res_nxt.c_we    = 1'b1;
               res_nxt.dc_we   = 1'b1;
               res_nxt.z_we    = 1'b1;
            end
            OP_AND_ACC_FILE:
            begin
               res_nxt.data = acc_r & file_rd_data_in;
               res_nxt.z_we = 1'b1;
            end
            OP_ADD_ACC_FILE, OP_ADD_ACC_FILE_CARRY_IN:
            begin
               res_nxt.data  = sum9[7:0];
               res_nxt.c_we  = 1'b1;
               res_nxt.dc_we = 1'b1;
               res_nxt.z_we  = 1'b1;
            end
            OP_ARITH_SHIFT_RIGHT_FILE:
            begin
               // Sign bit is kept, so this divides a signed byte by two
               res_nxt.data = {file_rd_data_in[`ACC_MSB], file_rd_data_in[7:1]};
               res_nxt.c_we = 1'b1;
               res_nxt.z_we = 1'b1;
            end
            OP_BIT_CLEAR_FILE:
            begin
               res_nxt.data    = file_rd_data_in
                                 & ~(8'h01 << opcode_in[`FLD_BIT_POS]);
               res_nxt.acc_we  = 1'b0;
               res_nxt.file_we = 1'b1;
            end
            default:
            begin
               // No operation: nothing is written
               res_nxt.acc_we  = 1'b0;
               res_nxt.file_we = 1'b0;
            end
         endcase
      end
      // Carry source differs for the shift; the others take the adder
      res_nxt.c  = (op_in == OP_ARITH_SHIFT_RIGHT_FILE) ? file_rd_data_in[0]
                                                        : sum9[8];
      res_nxt.dc = sum5[`NIBBLE_CARRY_BIT];
      res_nxt.z  = (res_nxt.data == 8'h00);
   end

   // Commit now, or one cycle later from the hold register
   assign do_commit = (accept && !stall) || (state_r == ST_EXTRA);
   assign commit    = (state_r == ST_EXTRA) ? hold_r : res_nxt;

   // Sequencer for the added indirect cycle
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
         state_r <= ST_RUN;
      else
      begin
         unique case (state_r)
            ST_RUN:
               if (accept && stall)
                  state_r <= ST_EXTRA;
            ST_EXTRA:
               state_r <= ST_RUN;
            default:
               state_r <= ST_RUN;
         endcase
      end
   end

   // Hold the result while the extra cycle runs; no issue can disturb it
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
         hold_r <= '0;
      else if (accept && stall)
         hold_r <= res_nxt;
   end

   // Handshake outputs
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         busy_r <= accept && stall;
         done_r <= do_commit;
      end
   end

   // Accumulator
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
         acc_r <= `ACC_RESET;
      else if (do_commit && commit.acc_we)
         acc_r <= commit.data;
   end

   // Status flags, each only when its enable is set
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         carry_r <= 1'b0;
         dc_r    <= 1'b0;
         zero_r  <= 1'b0;
      end
      else if (do_commit)
      begin
         if (commit.c_we)
            carry_r <= commit.c;
         if (commit.dc_we)
            dc_r <= commit.dc;
         if (commit.z_we)
            zero_r <= commit.z;
      end
   end

   // File write back, a one-cycle strobe with address and data
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         file_we_r   <= 1'b0;
         file_addr_r <= 7'h00;
         file_data_r <= 8'h00;
      end
      else
      begin
         file_we_r <= do_commit && commit.file_we;
         if (do_commit && commit.file_we)
         begin
            file_addr_r <= commit.file_addr;
            file_data_r <= commit.data;
         end
      end
   end

   // Pointer add wins over a direct load in the same cycle
   always_comb
   begin
      ptr_wr.we   = ptr_load_en_in;
      ptr_wr.sel  = ptr_load_sel_in;
      ptr_wr.data = ptr_load_data_in;
      if (do_commit && commit.ptr_we)
      begin
         ptr_wr.we   = 1'b1;
         ptr_wr.sel  = commit.ptr_sel;
         ptr_wr.data = commit.ptr_val;
      end
   end

   pointer_pair_store u_ptr_store
   (
      .clk_in   (clk_in),
      .srst_in  (srst_in),
      .wr_in    (ptr_wr),
      .ptr0_out (ptr0),
      .ptr1_out (ptr1)
   );

   assign busy_out                   = busy_r;
   assign done_out                   = done_r;
   assign file_we_out                = file_we_r;
   assign file_addr_out              = file_addr_r;
   assign file_data_out              = file_data_r;
   assign acc_out                    = acc_r;
   assign carry_out                  = carry_r;
   assign nibble_overflow_bit_out    = dc_r;
   assign zero_out                   = zero_r;
   assign indirect_pointer_pair0_out = ptr0;
   assign indirect_pointer_pair1_out = ptr1;
endmodule

// ===== hw/byte_alu_regs.svh
// Field positions, encodings and reset values for the byte ALU subset.
// Assumes it is included by bare name from the design modules.
`ifndef BYTE_ALU_REGS_SVH
`define BYTE_ALU_REGS_SVH

// Opcode fields
`define FLD_FILE_ADDR      6:0
`define FLD_DEST           7
`define FLD_BIT_POS        9:7
`define FLD_LIT8           7:0
`define FLD_LIT6           5:0
`define FLD_PTR_SEL        6
`define FLD_LIT6_SIGN      5
`define FLD_PTR_ADD_TOP    13:7
`define PTR_ADD_PATTERN    7'h62

// Indirect access register addresses and bit positions
`define PTR0_TARGET_ADDR   7'h00
`define PTR1_TARGET_ADDR   7'h01
`define PTR_MSB            15
`define ACC_MSB            7
`define NIBBLE_CARRY_BIT   4

// Reset values
`define ACC_RESET          8'h00
`define PTR_RESET          16'h0000

`endif

// ===== hw/byte_alu_pkg.sv
// Types shared by the byte ALU subset and its pointer store.
// Assumes the constants header sits beside it on the include path.
package byte_alu_pkg;

   // Operation chosen by the instruction decoder, one-hot
   typedef enum logic [7:0] {
      OP_NONE                  = 8'h01,
      OP_AND_LITERAL_ACC       = 8'h02,
      OP_ADD_LITERAL_ACC       = 8'h04,
      OP_AND_ACC_FILE          = 8'h08,
      OP_ADD_ACC_FILE          = 8'h10,
      OP_ADD_ACC_FILE_CARRY_IN = 8'h20,
      OP_ARITH_SHIFT_RIGHT_FILE= 8'h40,
      OP_BIT_CLEAR_FILE        = 8'h80
   } op_sel_type;

   typedef enum logic [1:0] {
      ST_RUN   = 2'h1,
      ST_EXTRA = 2'h2
   } exec_state_type;

   // Everything one instruction commits
   typedef struct packed {
      logic        acc_we;
      logic        file_we;
      logic [6:0]  file_addr;
      logic [7:0]  data;
      logic        c_we;
      logic        dc_we;
      logic        z_we;
      logic        c;
      logic        dc;
      logic        z;
      logic        ptr_we;
      logic        ptr_sel;
      logic [15:0] ptr_val;
   } exec_result_type;

   // Pointer write request into the store
   typedef struct packed {
      logic        we;
      logic        sel;
      logic [15:0] data;
   } ptr_write_type;

endpackage

// ===== hw/pointer_pair_store.sv
// Holds the two 16-bit indirect pointer pairs.
// Assumes one write per cycle, already arbitrated by the caller.
`timescale 1ns/100ps
`include "byte_alu_regs.svh"
module pointer_pair_store
(
   // Clock and reset
   input  wire logic                        clk_in,
   input  wire logic                        srst_in,
   // Write port
   input  wire byte_alu_pkg::ptr_write_type wr_in,
   // Registered pointer values
   output logic [15:0]                      ptr0_out,
   output logic [15:0]                      ptr1_out
);
   import byte_alu_pkg::*;

   logic [15:0] ptr_r [2];

   // One register per pointer pair
   for (genvar i = 0; i < 2; i++)
   begin : g_ptr
      always_ff @(posedge clk_in)
      begin
         if (srst_in)
            ptr_r[i] <= `PTR_RESET;
         else if (wr_in.we && (wr_in.sel == 1'(i)))
            ptr_r[i] <= wr_in.data;
      end
   end

   assign ptr0_out = ptr_r[0];
   assign ptr1_out = ptr_r[1];
endmodule

// ===== dv/byte_alu_subset_exec_sva.sv
// Port assertions for the byte ALU subset datapath.
// Assumes one clock domain; bound to every instance of the top module.
`timescale 1ns/100ps
module byte_alu_subset_exec_sva
(
   // Watched ports
   input wire logic                     clk_in,
   input wire logic                     srst_in,
   input wire logic                     issue_valid_in,
   input wire logic [13:0]              opcode_in,
   input wire byte_alu_pkg::op_sel_type op_in,
   input wire logic [7:0]               file_rd_data_in,
   input wire logic                     busy_out,
   input wire logic                     done_out,
   input wire logic                     file_we_out,
   input wire logic [7:0]               file_data_out,
   input wire logic [7:0]               acc_out,
   input wire logic                     carry_out,
   input wire logic                     nibble_overflow_bit_out,
   input wire logic                     zero_out,
   input wire logic [15:0]              indirect_pointer_pair0_out,
   input wire logic [15:0]              indirect_pointer_pair1_out
);
   import byte_alu_pkg::*;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);
   // Issue decode; pointer add wins over any op select
   wire        tk = issue_valid_in && !busy_out;
   wire        pa = opcode_in[13:7] == 7'h62;
   wire        fo = !pa && (op_in inside {OP_AND_ACC_FILE, OP_ADD_ACC_FILE,
                    OP_ADD_ACC_FILE_CARRY_IN, OP_ARITH_SHIFT_RIGHT_FILE, OP_BIT_CLEAR_FILE});
   wire        st = fo && opcode_in[6:1] == 6'h00 && (opcode_in[0] ?
                    indirect_pointer_pair1_out[15] : indirect_pointer_pair0_out[15]);
   wire        go = tk && !st && !pa;
   // Expected results, sampled at the take edge through $past
   wire [15:0] p0k = indirect_pointer_pair0_out + {{10{opcode_in[5]}}, opcode_in[5:0]};
   wire [7:0]  al = acc_out & opcode_in[7:0];
   wire [8:0]  sl = {1'b0, acc_out} + {1'b0, opcode_in[7:0]};
   wire [4:0]  hl = {1'b0, acc_out[3:0]} + {1'b0, opcode_in[3:0]};
   wire        hc = hl[4];
   wire        f0 = file_rd_data_in[0];
   wire [7:0]  bc = file_rd_data_in & ~(8'h01 << opcode_in[9:7]);
   // Stalled commit: one busy cycle, then done
   sequence s_stall;
      busy_out && !done_out ##1 done_out && !busy_out;
   endsequence
   a_issue_done:
      assert property (tk && !st |=> done_out && !busy_out) else $error("late commit");
   a_stall_extra:
      assert property (tk && st |=> s_stall) else $error("stall cycle wrong");
   a_busy_single:
      assert property (busy_out |=> !busy_out) else $error("busy too long");
   a_ptr0_add:
      assert property (tk && pa && !opcode_in[6] |=> indirect_pointer_pair0_out == $past(p0k))
      else $error("pointer sum wrong");
   a_ptr_flags:
      assert property (tk && pa |=> $stable(carry_out) && $stable(zero_out)
         && $stable(nibble_overflow_bit_out)) else $error("pointer add moved a flag");
   a_and_lit:
      assert property (go && op_in == OP_AND_LITERAL_ACC |=> acc_out == $past(al)
         && zero_out == (acc_out == 8'h00) && $stable(carry_out)) else $error("and literal");
   a_add_lit:
      assert property (go && op_in == OP_ADD_LITERAL_ACC |=> {carry_out, acc_out} == $past(sl)
         && nibble_overflow_bit_out == $past(hc)) else $error("add literal");
   a_shift_carry:
      assert property (go && op_in == OP_ARITH_SHIFT_RIGHT_FILE |=> carry_out == $past(f0))
      else $error("shift carry");
   a_clear_write:
      assert property (go && op_in == OP_BIT_CLEAR_FILE |=> file_we_out
         && file_data_out == $past(bc) && $stable(zero_out)) else $error("bit clear");
endmodule
bind byte_alu_subset_exec byte_alu_subset_exec_sva u_sva (.clk_in, .srst_in, .issue_valid_in,
   .opcode_in, .op_in, .file_rd_data_in, .busy_out, .done_out, .file_we_out, .file_data_out,
   .acc_out, .carry_out, .nibble_overflow_bit_out, .zero_out, .indirect_pointer_pair0_out,
   .indirect_pointer_pair1_out);

// ===== dv/file_mem_model.sv
// Data memory beside the ALU: 128 file registers with a preset pattern.
// Assumes the bench shadows the same pattern; reads are combinational.
`timescale 1ns/100ps
module file_mem_model
(
   // Clock
   input  wire logic       clk_in,
   // Read and write ports
   input  wire logic [6:0] rd_addr_in,
   output logic [7:0]      rd_data_out,
   input  wire logic       we_in,
   input  wire logic [6:0] wr_addr_in,
   input  wire logic [7:0] wr_data_in
);
   logic [7:0] mem [128];
   // Mixed pattern so neighbouring registers differ
   initial
   begin
      for (int i = 0; i < 128; i++)
         mem[i] = 8'(i * 37 + 17);
   end
   // Write lands on the edge after the pulse is seen
   always @(posedge clk_in)
   begin
      if (we_in)
         mem[wr_addr_in] <= wr_data_in;
   end
   assign rd_data_out = mem[rd_addr_in];
endmodule

// ===== dv/tb_byte_alu_subset_exec.sv
// Self-checking bench for the byte ALU subset datapath.
// Assumes the memory model and checker sit beside it; one 200 MHz clock.
`timescale 1ns/100ps
module tb_byte_alu_subset_exec;
   import byte_alu_pkg::*;
   logic        clk_in = 0, srst_in = 1, issue_valid_in = 0;
   logic        ptr_load_en_in = 0, ptr_load_sel_in = 0;
   logic [13:0] opcode_in = 14'h0000;
   op_sel_type  op_in = OP_NONE;
   logic [15:0] ptr_load_data_in = 16'h0000, e_p0 = 16'h0000, e_p1 = 16'h0000;
   logic [15:0] indirect_pointer_pair0_out, indirect_pointer_pair1_out;
   logic [7:0]  file_rd_data_in, file_data_out, acc_out, e_acc = 8'h00, sh [128];
   logic [6:0]  file_addr_out;
   logic        busy_out, done_out, file_we_out, carry_out, nibble_overflow_bit_out, zero_out;
   logic        e_c = 0, e_dc = 0, e_z = 0, hold_iss = 0;
   int          failures = 0, compares = 0;
   op_sel_type  ops [5] = '{OP_AND_ACC_FILE, OP_ADD_ACC_FILE, OP_ADD_ACC_FILE_CARRY_IN,
                            OP_ARITH_SHIFT_RIGHT_FILE, OP_BIT_CLEAR_FILE};
   // Clock
   initial forever #2.5 clk_in = ~clk_in;
   byte_alu_subset_exec u_dut (.clk_in, .srst_in, .issue_valid_in, .opcode_in, .op_in,
      .file_rd_data_in, .ptr_load_en_in, .ptr_load_sel_in, .ptr_load_data_in, .busy_out,
      .done_out, .file_we_out, .file_addr_out, .file_data_out, .acc_out, .carry_out,
      .nibble_overflow_bit_out, .zero_out, .indirect_pointer_pair0_out,
      .indirect_pointer_pair1_out);
   file_mem_model u_mem (.clk_in, .rd_addr_in(opcode_in[6:0]), .rd_data_out(file_rd_data_in),
      .we_in(file_we_out), .wr_addr_in(file_addr_out), .wr_data_in(file_data_out));
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("Compares %0d, mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Direct pointer load, one cycle
   task automatic load(input logic s, input logic [15:0] v);
      @(negedge clk_in);
      ptr_load_en_in = 1;
      ptr_load_sel_in = s;
      ptr_load_data_in = v;
      @(negedge clk_in);
      ptr_load_en_in = 0;
      if (s)
         e_p1 = v;
      else
         e_p0 = v;
   endtask
   // One instruction: predict, issue, wait for done, compare everything
   task automatic run(input op_sel_type op, input logic [13:0] oc);
      logic [7:0] b, r;
      logic [8:0] s;
      logic [4:0] h;
      logic       ci, dst, st, fop, lit, pa;
      int         n;
      pa = oc[13:7] == 7'h62;
      lit = op inside {OP_AND_LITERAL_ACC, OP_ADD_LITERAL_ACC};
      fop = !pa && !lit && op != OP_NONE;
      b = lit ? oc[7:0] : sh[oc[6:0]];
      ci = op == OP_ADD_ACC_FILE_CARRY_IN && e_c;
      s = e_acc + b + ci;
      h = e_acc[3:0] + b[3:0] + ci;
      st = fop && oc[6:1] == 6'h00 && (oc[0] ? e_p1[15] : e_p0[15]);
      dst = oc[7] || op == OP_BIT_CLEAR_FILE;
      r = b;
      if (pa && oc[6])
         e_p1 += {{10{oc[5]}}, oc[5:0]};
      else if (pa)
         e_p0 += {{10{oc[5]}}, oc[5:0]};
      else
         case (op)
            OP_AND_LITERAL_ACC, OP_AND_ACC_FILE:
            begin
               r = e_acc & b;
               e_z = r == 8'h00;
            end
            OP_ADD_LITERAL_ACC, OP_ADD_ACC_FILE, OP_ADD_ACC_FILE_CARRY_IN:
            begin
               r = s[7:0];
               {e_c, e_dc, e_z} = {s[8], h[4], r == 8'h00};
            end
            OP_ARITH_SHIFT_RIGHT_FILE:
            begin
               r = {b[7], b[7:1]};
               {e_c, e_z} = {b[0], r == 8'h00};
            end
            OP_BIT_CLEAR_FILE: r[oc[9:7]] = 1'b0;
            default: ;
         endcase
      @(negedge clk_in);
      issue_valid_in = 1;
      op_in = op;
      opcode_in = oc;
      @(posedge clk_in);
      @(negedge clk_in);
      // Held up into the busy cycle when the refusal is under test
      issue_valid_in = hold_iss;
      n = 1;
      while (done_out !== 1'b1 && n < 4)
      begin
         @(negedge clk_in);
         n++;
      end
      if (hold_iss)
         issue_valid_in = 0;
      if (n == 4)
      begin
         failures++;
         end_sim();
      end
      chk("cycles", 16'(n), st ? 16'h0002 : 16'h0001);
      if (fop && dst)
         sh[oc[6:0]] = r;
      else if (!pa && op != OP_NONE)
         e_acc = r;
      chk("file_we", file_we_out, fop && dst);
      if (fop && dst)
         chk("file_wr", {file_addr_out, file_data_out}, {oc[6:0], r});
      chk("acc", acc_out, e_acc);
      chk("flags", {carry_out, nibble_overflow_bit_out, zero_out}, {e_c, e_dc, e_z});
      chk("ptr0", indirect_pointer_pair0_out, e_p0);
      chk("ptr1", indirect_pointer_pair1_out, e_p1);
      // The issue seen during busy must not start a second instruction
      if (hold_iss)
      begin
         @(negedge clk_in);
         chk("refused", {done_out, file_we_out}, 16'h0000);
      end
   endtask
   // Main sequence
   initial
   begin
      for (int i = 0; i < 128; i++)
         sh[i] = 8'(i * 37 + 17);
      repeat (16) @(negedge clk_in);
      srst_in = 0;
      chk("reset", {acc_out, carry_out, nibble_overflow_bit_out, zero_out, busy_out, done_out},
          14'h0000);
      chk("reset_ptr", indirect_pointer_pair0_out | indirect_pointer_pair1_out, 16'h0000);
      // Pointer add wraps both ways, op select ignored
      load(0, 16'hFFF0);
      run(OP_ADD_ACC_FILE, 14'h311F);
      run(OP_NONE, 14'h3160);
      $display("test pointer_add done");
      // Literal ops through carry, nibble carry and zero
      run(OP_ADD_LITERAL_ACC, 14'h00FF);
      run(OP_ADD_LITERAL_ACC, 14'h0001);
      run(OP_ADD_LITERAL_ACC, 14'h003C);
      run(OP_AND_LITERAL_ACC, 14'h00F0);
      run(OP_AND_LITERAL_ACC, 14'h000F);
      $display("test literal done");
      // File ops to both destinations except bit clear, which always writes the file, then on the indirect targets
      for (int i = 0; i < 5; i++)
         for (int d = 0; d < 2; d++)
            run(ops[i], {4'h0, 2'(i), d[0], 7'(i + 9)});
      load(0, 16'h8000);
      hold_iss = 1;
      for (int i = 0; i < 5; i++)
         run(ops[i], {6'h00, i[0], 7'(i % 2)});
      hold_iss = 0;
      run(OP_ADD_LITERAL_ACC, 14'h0000);
      run(OP_NONE, 14'h0000);
      load(1, 16'h7FFF);
      run(OP_ADD_ACC_FILE, 14'h0081);
      // A direct load in the pointer add's issue cycle is lost to the add
      ptr_load_en_in = 1;
      ptr_load_sel_in = 0;
      ptr_load_data_in = 16'h1234;
      e_p0 = 16'h1234;
      run(OP_NONE, 14'h3101);
      ptr_load_en_in = 0;
      $display("test file done");
      end_sim();
   end
endmodule
